// file: thermal_alarm_device.sv
// alarm and interrupt logic of a two-channel thermometer
// assumes temperatures arrive from a converter front end, synchronous
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns

module thermal_alarm_device #(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary default address
) (
   input  wire logic           clk,
   input  wire logic           sys_rst,
   thermal_link_if.dev         link,
   input  wire logic [7:0]     local_meas,
   input  wire logic [7:0]     remote_meas,
   input  wire logic           diode_open,
   output      logic           converting
);
   import thermal_alarm_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  ptr_q, local_q, remote_q, status_q, cfg_q;
   logic [7:0]  lhigh_q, llow_q, rhigh_q, rlow_q, lcrit_q, rcrit_q;
   logic [7:0]  critical_hysteresis_q;
   logic [11:0] conv_cnt_q;
   logic        busy_q, single_q, open_q, alarm_q, ara_q;
   logic        lcrit_st_q, rcrit_st_q, l2_st_q, r2_st_q;
   logic        rsp_valid_q, alarm_oe_n_q, crit_n_q;
   logic [7:0]  rsp_data_q;

   // set above limit, release at limit minus hysteresis, floor at zero
   function automatic logic hyst_next(input logic       prev,
                                      input logic [7:0] t,
                                      input logic [7:0] lim,
                                      input logic [7:0] hy);
      logic [8:0] rel;
      rel = {1'b0, lim} - {1'b0, hy};
      if (rel[8]) begin
         rel = 9'h000;
      end
      return (t > lim) || (prev && ({1'b0, t} > rel));
   endfunction : hyst_next

   // ----------------------------------------------------------------
   // transaction decode
   // ----------------------------------------------------------------
   wire wr_any  = link.txn_valid && (link.txn_kind == K_WRITE);
   wire ptr_ld  = link.txn_valid &&
                  (link.txn_kind == K_PTR || link.txn_kind == K_WRITE);
   wire rd_req  = link.txn_valid && (link.txn_kind == K_READ);
   wire ara_req = link.txn_valid && (link.txn_kind == K_ARA);
   // data goes where the byte just loaded points
   wire wr_cfg   = wr_any && (link.txn_ptr == P_CFG_WR);
   wire wr_lhigh = wr_any && (link.txn_ptr == P_LHIGH_WR);
   wire wr_llow  = wr_any && (link.txn_ptr == P_LLOW_WR);
   wire wr_rhigh = wr_any && (link.txn_ptr == P_RHIGH_WR);
   wire wr_rlow  = wr_any && (link.txn_ptr == P_RLOW_WR);
   wire wr_lcrit = wr_any && (link.txn_ptr == P_LCRIT);
   wire wr_rcrit = wr_any && (link.txn_ptr == P_RCRIT);
   wire wr_hyst  = wr_any && (link.txn_ptr == P_HYST);
   wire wr_single = wr_any && (link.txn_ptr == P_SINGLE);
   wire st_read  = rd_req && (ptr_q == P_STATUS);

   // read mux; write-only locations answer zero
   logic [7:0] rd_val;
   always_comb begin
      case (ptr_q)
         P_LOCAL:    rd_val = local_q;
         P_REMOTE:   rd_val = remote_q;
         P_STATUS:   rd_val = status_q;
         P_CFG_RD:   rd_val = cfg_q;
         P_LHIGH_RD: rd_val = lhigh_q;
         P_LLOW_RD:  rd_val = llow_q;
         P_RHIGH_RD: rd_val = rhigh_q;
         P_RLOW_RD:  rd_val = rlow_q;
         P_LCRIT:    rd_val = lcrit_q;
         P_RCRIT:    rd_val = rcrit_q;
         P_HYST:     rd_val = critical_hysteresis_q;
         default:    rd_val = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // live comparisons on stored values
   // ----------------------------------------------------------------
   wire standby  = cfg_q[CFG_STANDBY];
   wire lh = local_q > lhigh_q;
   wire ll = local_q <= llow_q;
   wire rh = remote_q > rhigh_q;
   wire rl = remote_q <= rlow_q;
   // no gating by standby, so fresh limits alarm at once
   wire [7:0] cond = {1'b0, lh, ll, rh, rl, open_q,
                      rcrit_st_q, lcrit_st_q};
   wire alarm_cause = |(cond & ST_ALARM_BITS);
   wire pin2_mode   = cfg_q[CFG_PIN2];
   wire secondary_overtemp_n = !(l2_st_q || r2_st_q);
   wire alarm_shown = alarm_q && !cfg_q[CFG_MASK];
   wire pin_low = pin2_mode ? !secondary_overtemp_n
                            : alarm_shown;
   // answer the alert read only while our alarm pulls the line
   wire ara_answer = ara_req && !pin2_mode && alarm_shown;
   // wired AND: a lower address elsewhere changes the bus value
   wire ara_won = ara_q && (link.rsp_bus == rsp_data_q);
   wire status_idle = (status_q & ST_ALARM_BITS) == 8'h00;
   wire conv_start = !busy_q && (!standby || single_q);
   wire conv_abort = busy_q && standby && !single_q;
   wire conv_end   = busy_q && !conv_abort && (conv_cnt_q == 12'h000);

   // ----------------------------------------------------------------
   // serial-side registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ptr_q   <= 8'h00;
         cfg_q   <= CFG_RST;
         lhigh_q <= HIGH_RST;
         llow_q  <= LOW_RST;
         rhigh_q <= HIGH_RST;
         rlow_q  <= LOW_RST;
         lcrit_q <= CRIT_RST;
         rcrit_q <= CRIT_RST;
         critical_hysteresis_q <= HYST_RST;
      end else begin
         if (ptr_ld) ptr_q <= link.txn_ptr;
         if (wr_cfg) cfg_q <= link.txn_data;
         if (wr_lhigh) lhigh_q <= link.txn_data;
         if (wr_llow) llow_q <= link.txn_data;
         if (wr_rhigh) rhigh_q <= link.txn_data;
         if (wr_rlow) rlow_q <= link.txn_data;
         if (wr_lcrit) lcrit_q <= link.txn_data;
         if (wr_rcrit) rcrit_q <= link.txn_data;
         if (wr_hyst) critical_hysteresis_q <= link.txn_data;
      end
   end

   // answers: one cycle after the request, bus released otherwise
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= BUS_IDLE;
         ara_q       <= 1'b0;
      end else begin
         rsp_valid_q <= rd_req || ara_answer;
         ara_q       <= ara_answer;
         if (ara_answer) begin
            rsp_data_q <= {DEV_ADDR, 1'b1};
         end else if (rd_req) begin
            rsp_data_q <= rd_val;
         end else begin
            rsp_data_q <= BUS_IDLE;
         end
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_q     <= 1'b0;
         single_q   <= 1'b0;
         open_q     <= 1'b0;
         conv_cnt_q <= 12'h000;
         local_q    <= 8'h00;
         remote_q   <= 8'h00;
      end else begin
         // data byte of this write is ignored
         if (wr_single && standby) single_q <= 1'b1;
         else if (conv_end) single_q <= 1'b0;
         if (conv_start) begin
            busy_q     <= 1'b1;
            open_q     <= diode_open;
            conv_cnt_q <= CONV_CYCLES - 12'h001;
         end else if (conv_abort) begin
            busy_q <= 1'b0;
         end else if (conv_end) begin
            busy_q   <= 1'b0;
            local_q  <= local_meas;
            remote_q <= remote_meas;
         end else if (busy_q) begin
            conv_cnt_q <= conv_cnt_q - 12'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // status, alarm latch and over-temperature states
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_q   <= 8'h00;
         alarm_q    <= 1'b0;
         lcrit_st_q <= 1'b0;
         rcrit_st_q <= 1'b0;
         l2_st_q    <= 1'b0;
         r2_st_q    <= 1'b0;
      end else begin
         // read clears, a live condition sets in the same cycle
         status_q <= (st_read ? 8'h00 : status_q) | cond;
         if (alarm_cause) begin
            alarm_q <= 1'b1;
         end else if (ara_won && status_idle) begin
            alarm_q <= 1'b0;
         end
         lcrit_st_q <= hyst_next(lcrit_st_q, local_q, lcrit_q,
                                 critical_hysteresis_q);
         rcrit_st_q <= hyst_next(rcrit_st_q, remote_q, rcrit_q,
                                 critical_hysteresis_q);
         l2_st_q <= hyst_next(l2_st_q, local_q, lhigh_q,
                              critical_hysteresis_q);
         r2_st_q <= hyst_next(r2_st_q, remote_q, rhigh_q,
                              critical_hysteresis_q);
      end
   end

   // pin flops; critical output has no mask term at all
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alarm_oe_n_q <= 1'b1;
         crit_n_q     <= 1'b1;
      end else begin
         alarm_oe_n_q <= !pin_low;
         crit_n_q     <= !(lcrit_st_q || rcrit_st_q);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.rsp_valid           = rsp_valid_q;
   assign link.rsp_data            = rsp_data_q;
   assign link.alarm_out           = 1'b0;
   assign link.alarm_oe_n          = alarm_oe_n_q;
   assign link.critical_overtemp_n = crit_n_q;
   assign converting               = busy_q;

endmodule : thermal_alarm_device

// file: thermal_alarm_host.sv
// bus controller end: turns software orders into link transactions
// assumes one device on the link and synchronous software strobes
`timescale 1ns/1ns
module thermal_alarm_host (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   thermal_link_if.host    link,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output      logic [7:0] rdata,
   output      logic       irq
);
   import thermal_alarm_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]   ptr_q, data_q, ans_q, rdata_q;
   logic [3:0]   status_q, enable_q;
   logic         auto_q, txn_valid_q, wait1_q, wait2_q;
   txn_kind_type kind_q;

   wire idle     = !txn_valid_q && !wait1_q && !wait2_q;
   wire sw_cmd   = wr && (addr == H_CMD) && idle;
   // repeat the alert read while the shared line stays low
   wire auto_ara = auto_q && !link.alarm_line && idle && !sw_cmd;
   // the answer stands in the cycle after the device took the request
   wire ans_in   = wait1_q && link.rsp_valid;
   wire noans    = wait1_q && !link.rsp_valid;
   wire [3:0] evt;
   assign evt[HI_DONE]  = wait2_q;
   assign evt[HI_ALARM] = !link.alarm_line;
   assign evt[HI_CRIT]  = !link.critical_overtemp_n;
   assign evt[HI_NOANS] = noans;
   wire [3:0] clr = (wr && addr == H_CLEAR) ? wdata[3:0] : 4'h0;

   // read mux for the software port
   logic [7:0] rd_val;
   always_comb begin
      case (addr)
         H_PTR:    rd_val = ptr_q;
         H_DATA:   rd_val = data_q;
         H_RDATA:  rd_val = ans_q;
         H_STATUS: rd_val = {4'h0, status_q};
         H_ENABLE: rd_val = {4'h0, enable_q};
         H_CTRL:   rd_val = {7'h00, auto_q};
         H_LINES:  rd_val = {6'h00, link.critical_overtemp_n,
                             link.alarm_line};
         default:  rd_val = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ptr_q    <= 8'h00;
         data_q   <= 8'h00;
         enable_q <= 4'h0;
         auto_q   <= 1'b0;
         status_q <= 4'h0;
         rdata_q  <= 8'h00;
      end else begin
         if (wr && addr == H_PTR) ptr_q <= wdata;
         if (wr && addr == H_DATA) data_q <= wdata;
         if (wr && addr == H_ENABLE) enable_q <= wdata[3:0];
         if (wr && addr == H_CTRL) auto_q <= wdata[0];
         // a new event wins over a clear in the same cycle
         status_q <= (status_q & ~clr) | evt;
         if (rd) rdata_q <= rd_val;
      end
   end

   // ----------------------------------------------------------------
   // link transactions; answer expected two edges after launch
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txn_valid_q <= 1'b0;
         kind_q      <= K_PTR;
         wait1_q     <= 1'b0;
         wait2_q     <= 1'b0;
         ans_q       <= BUS_IDLE;
      end else begin
         txn_valid_q <= sw_cmd || auto_ara;
         if (sw_cmd) kind_q <= txn_kind_type'(wdata[1:0]);
         else if (auto_ara) kind_q <= K_ARA;
         wait1_q <= txn_valid_q && (kind_q == K_READ || kind_q == K_ARA);
         wait2_q <= wait1_q;
         // a lost arbitration reads as another device's address
         if (ans_in) ans_q <= link.rsp_bus;
         else if (noans) ans_q <= BUS_IDLE;
      end
   end

   // pointer and data both travel with a write; read uses stored pointer
   assign link.txn_valid = txn_valid_q;
   assign link.txn_kind  = kind_q;
   assign link.txn_ptr   = ptr_q;
   assign link.txn_data  = data_q;
   assign rdata          = rdata_q;
   assign irq            = |(status_q & enable_q);

endmodule : thermal_alarm_host

// file: thermal_alarm_interrupt_logic_tb.sv
// self-checking bench: controller and device joined over the link
// assumes package constants and one 20 MHz clock
`timescale 1ns/1ns
module thermal_alarm_interrupt_logic_tb;
   import thermal_alarm_pkg::*;
   localparam logic [6:0] ADDR = 7'h2a;  // arbitrary device address
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       sw_wr = 1'b0;
   logic       sw_rd = 1'b0;
   logic [7:0] rdata;
   logic       irq;
   logic       converting;
   logic [7:0] local_meas = 8'h40;
   logic [7:0] remote_meas = 8'h40;
   logic       diode_open = 1'b0;
   int         error_cnt = 0;
   int         n_tests = 0;
   logic [7:0] dp [5] = '{P_LCRIT, P_RCRIT, P_HYST, P_LHIGH_RD, P_SINGLE};
   logic [7:0] dv [5] = '{8'h55, 8'h55, 8'h0a, 8'h55, 8'h00};

   always #25 clk = ~clk;
   thermal_link_if link ();
   thermal_alarm_device #(.DEV_ADDR(ADDR)) i_thermal_alarm_device (
      .clk(clk), .sys_rst(sys_rst), .link(link), .local_meas(local_meas),
      .remote_meas(remote_meas), .diode_open(diode_open),
      .converting(converting));
   thermal_alarm_host i_thermal_alarm_host (
      .clk(clk), .sys_rst(sys_rst), .link(link), .addr(addr),
      .wdata(wdata), .wr(sw_wr), .rd(sw_rd), .rdata(rdata), .irq(irq));
   thermal_alarm_properties #(.DEV_ADDR(ADDR)) i_thermal_alarm_properties (
      .clk(clk), .sys_rst(sys_rst), .txn_valid(link.txn_valid),
      .txn_kind(link.txn_kind), .txn_ptr(link.txn_ptr),
      .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
      .alarm_oe_n(link.alarm_oe_n));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask : reg_wr
   // read data stands from the cycle after the strobe until the next read
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] e,
                         input logic [7:0] m = 8'hff);
      @(posedge clk);
      addr  <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask : reg_rd
   // fixed wait covers the controller's busy window
   task automatic dev(input txn_kind_type k, input logic [7:0] p,
                      input logic [7:0] d);
      reg_wr(H_PTR, p);
      reg_wr(H_DATA, d);
      reg_wr(H_CMD, {6'h00, k});
      repeat (4) @(posedge clk);
   endtask : dev
   task automatic rdv(input logic [7:0] p, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
      dev(K_PTR, p, 8'h00);
      dev(K_READ, 8'h00, 8'h00);
      reg_rd(H_RDATA, e, m);
   endtask : rdv
   // one conversion plus margin
   task automatic conv();
      repeat (2100) @(posedge clk);
   endtask : conv
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rdv(dp[i], dv[i]);
      end
      $display("test defaults done");
      reg_rd(H_LINES, 8'h02);
      reg_wr(H_ENABLE, 8'h02);
      #1;
      chk({7'h00, irq}, 8'h01);
      dev(K_ARA, 8'h00, 8'h00);
      reg_rd(H_RDATA, {ADDR, 1'b1});
      reg_rd(H_LINES, 8'h02);
      conv();
      dev(K_ARA, 8'h00, 8'h00);
      reg_rd(H_LINES, 8'h02);
      rdv(P_STATUS, 8'h28);
      dev(K_ARA, 8'h00, 8'h00);
      reg_rd(H_LINES, 8'h03);
      reg_wr(H_CLEAR, 8'hff);
      #1;
      chk({7'h00, irq}, 8'h00);
      $display("test alert service done");
      // standby: the running conversion is dropped
      dev(K_WRITE, P_CFG_WR, 8'h40);
      local_meas <= 8'h5a;
      conv();
      reg_rd(H_LINES, 8'h03);
      chk({7'h00, converting}, 8'h00);
      // high limit kept below the critical limits
      dev(K_WRITE, P_LHIGH_WR, 8'h30);
      reg_rd(H_LINES, 8'h02);
      // auto repeat of the alert read while the line stays low
      reg_wr(H_CLEAR, 8'h0f);
      reg_wr(H_CTRL, 8'h01);
      repeat (8) @(posedge clk);
      reg_wr(H_CTRL, 8'h00);
      repeat (4) @(posedge clk);
      reg_rd(H_STATUS, 8'h01, 8'h01);
      dev(K_WRITE, P_SINGLE, 8'h00);
      #1;
      chk({7'h00, converting}, 8'h01);
      conv();
      reg_rd(H_LINES, 8'h00);
      dev(K_WRITE, P_CFG_WR, 8'hc0);
      reg_rd(H_LINES, 8'h01);
      dev(K_WRITE, P_CFG_WR, 8'he0);
      reg_rd(H_LINES, 8'h00);
      dev(K_ARA, 8'h00, 8'h00);
      reg_rd(H_RDATA, 8'hff);
      reg_rd(H_STATUS, 8'h08, 8'h08);
      $display("test standby and pin modes done");
      // hysteresis: above the release point, then exactly on it
      dev(K_WRITE, P_HYST, 8'h05);
      local_meas <= 8'h52;
      dev(K_WRITE, P_SINGLE, 8'h00);
      conv();
      reg_rd(H_LINES, 8'h00);
      @(posedge clk);
      local_meas <= 8'h50;
      diode_open <= 1'b1;
      dev(K_WRITE, P_SINGLE, 8'h00);
      conv();
      reg_rd(H_LINES, 8'h02);
      rdv(P_STATUS, 8'h04, 8'h04);
      $display("test hysteresis and open diode done");
      report_and_stop();
   end
endmodule : thermal_alarm_interrupt_logic_tb

// file: thermal_alarm_pkg.sv
// shared constants of the thermometer alarm logic and its bus controller
// assumes one 20 MHz clock and a transaction-level serial bus model
package thermal_alarm_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int          CLK_MHZ      = 20;
   localparam int          CONV_TIME_US = 100;
   localparam logic [11:0] CONV_CYCLES  = 12'(CONV_TIME_US * CLK_MHZ);

   // ----------------------------------------------------------------
   // device pointer values (read and write locations)
   // ----------------------------------------------------------------
   localparam logic [7:0] P_LOCAL     = 8'h00;
   localparam logic [7:0] P_REMOTE    = 8'h01;
   localparam logic [7:0] P_STATUS    = 8'h02;
   localparam logic [7:0] P_CFG_RD    = 8'h03;
   localparam logic [7:0] P_LHIGH_RD  = 8'h05;
   localparam logic [7:0] P_LLOW_RD   = 8'h06;
   localparam logic [7:0] P_RHIGH_RD  = 8'h07;
   localparam logic [7:0] P_RLOW_RD   = 8'h08;
   localparam logic [7:0] P_CFG_WR    = 8'h09;
   localparam logic [7:0] P_LHIGH_WR  = 8'h0b;
   localparam logic [7:0] P_LLOW_WR   = 8'h0c;
   localparam logic [7:0] P_RHIGH_WR  = 8'h0d;
   localparam logic [7:0] P_RLOW_WR   = 8'h0e;
   localparam logic [7:0] P_SINGLE    = 8'h0f;
   localparam logic [7:0] P_RCRIT     = 8'h19;
   localparam logic [7:0] P_LCRIT     = 8'h20;
   localparam logic [7:0] P_HYST      = 8'h21;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] HIGH_RST = 8'h55;
   localparam logic [7:0] LOW_RST  = 8'h00;
   localparam logic [7:0] CRIT_RST = 8'h55;
   localparam logic [7:0] HYST_RST = 8'h0a;
   localparam logic [7:0] CFG_RST  = 8'h00;

   // ----------------------------------------------------------------
   // configuration and status fields
   // ----------------------------------------------------------------
   localparam int CFG_MASK    = 7;
   localparam int CFG_STANDBY = 6;
   localparam int CFG_PIN2    = 5;
   localparam int ST_LHIGH    = 6;
   localparam int ST_LLOW     = 5;
   localparam int ST_RHIGH    = 4;
   localparam int ST_RLOW     = 3;
   localparam int ST_OPEN     = 2;
   localparam int ST_RCRIT    = 1;
   localparam int ST_LCRIT    = 0;
   localparam logic [7:0] ST_ALARM_BITS = 8'h7c;

   // alert response address, seven bits
   localparam logic [6:0] ARA_ADDR = 7'h0c;
   localparam logic [7:0] BUS_IDLE = 8'hff;

   typedef enum logic [1:0] {K_PTR, K_WRITE, K_READ, K_ARA} txn_kind_type;

   // ----------------------------------------------------------------
   // controller register offsets and fields
   // ----------------------------------------------------------------
   localparam logic [3:0] H_CMD    = 4'h0;
   localparam logic [3:0] H_PTR    = 4'h1;
   localparam logic [3:0] H_DATA   = 4'h2;
   localparam logic [3:0] H_RDATA  = 4'h3;
   localparam logic [3:0] H_STATUS = 4'h4;
   localparam logic [3:0] H_CLEAR  = 4'h5;
   localparam logic [3:0] H_ENABLE = 4'h6;
   localparam logic [3:0] H_CTRL   = 4'h7;
   localparam logic [3:0] H_LINES  = 4'h8;
   localparam int HI_DONE  = 0;
   localparam int HI_ALARM = 1;
   localparam int HI_CRIT  = 2;
   localparam int HI_NOANS = 3;

endpackage : thermal_alarm_pkg

// file: thermal_alarm_properties.sv
// link properties of the thermometer alarm logic and its controller
// assumes one clock domain, sync active-high reset, one device
`timescale 1ns/1ns
module thermal_alarm_properties #(
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   input wire logic                            clk,
   input wire logic                            sys_rst,
   input wire logic                            txn_valid,
   input wire thermal_alarm_pkg::txn_kind_type txn_kind,
   input wire logic [7:0]                      txn_ptr,
   input wire logic                            rsp_valid,
   input wire logic [7:0]                      rsp_data,
   input wire logic                            alarm_oe_n
);
   import thermal_alarm_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // shadow of the device pointer, so reads can be judged by place
   logic [7:0] ptr_q;
   always_ff @(posedge clk) begin
      if (sys_rst) ptr_q <= 8'h00;
      else if (txn_valid && (txn_kind == K_PTR || txn_kind == K_WRITE))
         ptr_q <= txn_ptr;
   end

   // request decode
   wire rd_go  = txn_valid && txn_kind == K_READ;
   wire ara_go = txn_valid && txn_kind == K_ARA;
   wire wr_go  = txn_valid && (txn_kind == K_PTR || txn_kind == K_WRITE);
   sequence ara_answered;
      ara_go ##1 rsp_valid;
   endsequence

   a_read_answers :
      assert property (rd_go |=> rsp_valid) else $error("read lost");
   a_write_silent :
      assert property (wr_go |=> !rsp_valid) else $error("write answered");
   a_wo_zero :
      assert property (rd_go && ptr_q == P_SINGLE |=> rsp_data == 8'h00)
      else $error("write-only place read nonzero");
   a_ara_reply :
      assert property (ara_answered |-> rsp_data == {DEV_ADDR, 1'b1})
      else $error("bad alert answer");
   a_bus_released :
      assert property (!rsp_valid |-> rsp_data == BUS_IDLE)
      else $error("answer bus not released");
   a_ara_hold :
      assert property (ara_answered |=> !alarm_oe_n)
      else $error("alarm dropped too early");
   a_host_spacing :
      assert property (rd_go || ara_go |=> !txn_valid [*2])
      else $error("request during answer");
   a_answer_cause :
      assert property (rsp_valid |-> $past(rd_go) || $past(ara_go))
      else $error("answer without request");
endmodule : thermal_alarm_properties

// file: thermal_link_if.sv
// link between the thermometer alarm logic and its bus controller
// assumes both ends on one clock; pullups are modelled here
`timescale 1ns/1ns
interface thermal_link_if;
   logic                            txn_valid;
   thermal_alarm_pkg::txn_kind_type txn_kind;
   logic [7:0]                      txn_ptr;
   logic [7:0]                      txn_data;
   logic                            rsp_valid;
   logic [7:0]                      rsp_data;
   logic [7:0]                      rsp_bus;
   logic                            alarm_out;
   logic                            alarm_oe_n;
   logic                            alarm_line;
   logic                            critical_overtemp_n;

   // pulled-up shared lines; answer bus is a wired AND of one device
   assign alarm_line = alarm_oe_n ? 1'b1 : alarm_out;
   assign rsp_bus    = rsp_data;

   modport dev (input txn_valid, txn_kind, txn_ptr, txn_data, rsp_bus,
                output rsp_valid, rsp_data, alarm_out, alarm_oe_n,
                critical_overtemp_n);
   modport host (output txn_valid, txn_kind, txn_ptr, txn_data,
                 input rsp_valid, rsp_bus, alarm_line, critical_overtemp_n);
endinterface : thermal_link_if
